/* File: logic/idregs_pkg.sv */
// package: register map, field layout and timing of the id/scratch/flash-count bank
package idregs_pkg;
   localparam logic [6:0] ADDR_GLOBAL_COMMAND = 7'h68;
   localparam logic [6:0] ADDR_DIAG_STATUS = 7'h02;
   localparam logic [6:0] ADDR_PRODUCT_IDENTIFIER = 7'h72;
   localparam logic [6:0] ADDR_LOT_SERIAL_NUMBER = 7'h74;
   localparam logic [6:0] ADDR_USER_SCRATCH_A = 7'h76;
   localparam logic [6:0] ADDR_USER_SCRATCH_B = 7'h78;
   localparam logic [6:0] ADDR_USER_SCRATCH_C = 7'h7a;
   localparam logic [6:0] ADDR_FLASH_WRITES_LOW_WORD = 7'h7c;
   localparam logic [6:0] ADDR_FLASH_WRITES_HIGH_WORD = 7'h7e;
   localparam int CMD_FLASH_UPDATE_BIT = 3;
   localparam int DIAG_FLASH_FAIL_BIT = 2;
   localparam logic [15:0] SCRATCH_RESET = 16'h0000;
   localparam logic [31:0] FLASH_COUNT_RESET = 32'h0000_0000;
   localparam int FLASH_UPDATE_TIME_NS = 400;
   localparam int CLK_PERIOD_NS = 4;
   localparam int FLASH_UPDATE_CYCLES = FLASH_UPDATE_TIME_NS / CLK_PERIOD_NS;

   // one register-port request from the serial front end
   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] addr;
      logic [15:0] wdata;
   } reg_req_type;

   // answer to a read, and the busy indication
   typedef struct packed {
      logic rvalid;
      logic [15:0] rdata;
      logic busy;
   } reg_rsp_type;
endpackage : idregs_pkg

/* File: logic/flash_commit.sv */
// flash commit sequencer: timed write cycle that reports done and pass/fail
`timescale 1ns/10ps
`default_nettype none
module flash_commit #(
   parameter int CYCLES = 100
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic fault,
   output logic busy,
   output logic done,
   output logic failed
);
   logic [$clog2(CYCLES+1)-1:0] count_reg;

   // busy stretches for CYCLES clocks; done pulses in the clock after the last one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         failed <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            count_reg <= ($clog2(CYCLES+1))'(CYCLES - 1);
            busy <= 1'b1;
            failed <= 1'b0;
         end else if (busy) begin
            if (count_reg == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
               failed <= fault; // sampled at the end of the write cycle
            end else begin
               count_reg <= count_reg - 1'b1;
            end
         end
      end
   end
endmodule : flash_commit
`default_nettype wire

/* File: logic/id_scratch_flashcount_regs.sv */
// register bank: product id, lot serial, user scratch words and flash write counter
`timescale 1ns/10ps
`default_nettype none
module id_scratch_flashcount_regs #(
   parameter logic [15:0] PRODUCT_CODE = 16'h1234, // arbitrary value
   parameter logic [15:0] LOT_SERIAL = 16'h0001,
   parameter int FLASH_CYCLES = idregs_pkg::FLASH_UPDATE_CYCLES
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire idregs_pkg::reg_req_type REQ,
   input wire logic FLASH_FAULT,
   output idregs_pkg::reg_rsp_type RSP,
   output logic DATA_READY_HOLD
);
   import idregs_pkg::*;

   // how the bank behaves at its port:
   //  - one request per cycle, rd or wr, addressed by the even byte address of a word
   //  - a taken read answers exactly one cycle later with rvalid and the word
   //  - a taken write stores at once; read-only and unmapped words drop it
   //  - a command write with the update bit raises busy at the accepting edge
   //  - while busy stands every request is dropped, nothing is queued
   //  - busy falls one cycle after the write cycle ends, so the count and the
   //    result bit are already updated when the first request after it is taken
   //  - the data-ready hold follows busy exactly, so sample production and the
   //    port resume together
   // the flash itself is not modelled: scratch words and count restart from zero
   // at reset, and the outcome of a write cycle comes in on FLASH_FAULT

   // number of user scratch words behind the port
   localparam int SCRATCH_WORDS = 3;

   // scratch storage, one flop word per user location
   logic [15:0] scratch_reg [SCRATCH_WORDS];

   // endurance count and its next value
   logic [31:0] flash_count_reg;
   logic [31:0] flash_count_next;

   // result of the most recent commit attempt, high when it failed
   logic diag_fail_reg;
   logic [15:0] diag_word;

   // launch strobe to the sequencer, one clock wide
   logic commit_start_reg;

   // sequencer status
   logic commit_busy;
   logic commit_done;
   logic commit_failed;

   // request qualifiers
   logic take;
   logic rd_take;
   logic wr_take;
   logic cmd_take;
   logic busy_next;

   // scratch write enables, one per word
   logic [SCRATCH_WORDS-1:0] scratch_we;

   // word selected by the read address
   logic [15:0] rdata_next;

   // requests arriving while a command runs are dropped, not queued; the registered
   // busy flag is the only gate, so host and bank always agree on what is refused
   assign take = !RSP.busy;
   assign rd_take = take && REQ.rd;
   assign wr_take = take && REQ.wr;

   // only the update bit acts; the other command bits belong to functions not built here
   assign cmd_take = wr_take && (REQ.addr == ADDR_GLOBAL_COMMAND)
      && REQ.wdata[CMD_FLASH_UPDATE_BIT];

   // busy covers the accepting edge, the launch cycle, the write cycle and one more
   assign busy_next = cmd_take || commit_start_reg || commit_busy;

   // timed write cycle; counts FLASH_CYCLES clocks and samples the fault at its end
   flash_commit #(
      .CYCLES(FLASH_CYCLES)
   ) u_commit (
      .clk(MCLK),
      .rst_n(RST_N),
      .start(commit_start_reg),
      .fault(FLASH_FAULT),
      .busy(commit_busy),
      .done(commit_done),
      .failed(commit_failed)
   );

   // command register: a taken write with the update bit launches the flash commit
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         commit_start_reg <= 1'b0;
      end else begin
         commit_start_reg <= cmd_take;
      end
   end

   // scratch write decode; read-only and unmapped words get no enable, so writes fall away
   always_comb begin
      scratch_we = '0;
      if (wr_take) begin
         case (REQ.addr)
            ADDR_USER_SCRATCH_A: scratch_we[0] = 1'b1;
            ADDR_USER_SCRATCH_B: scratch_we[1] = 1'b1;
            ADDR_USER_SCRATCH_C: scratch_we[2] = 1'b1;
            default: scratch_we = '0;
         endcase
      end
   end

   // scratch words; every reset clears them, a commit does not keep them
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         for (int i = 0; i < SCRATCH_WORDS; i++) begin
            scratch_reg[i] <= SCRATCH_RESET;
         end
      end else begin
         for (int i = 0; i < SCRATCH_WORDS; i++) begin
            if (scratch_we[i]) begin
               scratch_reg[i] <= REQ.wdata;
            end
         end
      end
   end

   // full 32-bit increment; the carry out of the low word moves into the high word.
   // the count wraps to zero after all ones, far beyond the flash's service life
   always_comb begin
      flash_count_next = flash_count_reg;
      if (commit_done) begin
         flash_count_next = flash_count_reg + 32'h0000_0001;
      end
   end

   // write counter, advanced once per finished flash cycle
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         flash_count_reg <= FLASH_COUNT_RESET;
      end else begin
         flash_count_reg <= flash_count_next;
      end
   end

   // result flag of the last commit attempt; only a finished cycle changes it
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         diag_fail_reg <= 1'b0;
      end else if (commit_done) begin
         diag_fail_reg <= commit_failed;
      end
   end

   // status word with only the commit result bit defined, the rest reads as zero
   always_comb begin
      diag_word = 16'h0000;
      diag_word[DIAG_FLASH_FAIL_BIT] = diag_fail_reg;
   end

   // read decode; the two count halves are not snapshotted, so a host that reads
   // both must not let a commit end between the two reads
   always_comb begin
      rdata_next = 16'h0000;
      case (REQ.addr)
         ADDR_PRODUCT_IDENTIFIER: rdata_next = PRODUCT_CODE;
         ADDR_LOT_SERIAL_NUMBER: rdata_next = LOT_SERIAL;
         ADDR_USER_SCRATCH_A: rdata_next = scratch_reg[0];
         ADDR_USER_SCRATCH_B: rdata_next = scratch_reg[1];
         ADDR_USER_SCRATCH_C: rdata_next = scratch_reg[2];
         ADDR_FLASH_WRITES_LOW_WORD: rdata_next = flash_count_reg[15:0];
         ADDR_FLASH_WRITES_HIGH_WORD: rdata_next = flash_count_reg[31:16];
         ADDR_DIAG_STATUS: rdata_next = diag_word;
         default: rdata_next = 16'h0000;
      endcase
   end

   // read answer: valid for exactly one cycle, data forced to zero otherwise
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         RSP.rvalid <= 1'b0;
         RSP.rdata <= 16'h0000;
      end else begin
         RSP.rvalid <= rd_take;
         RSP.rdata <= rd_take ? rdata_next : 16'h0000;
      end
   end

   // busy flag seen by the host; it also gates the port, one flop for both
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         RSP.busy <= 1'b0;
      end else begin
         RSP.busy <= busy_next;
      end
   end

   // data-ready pulsing is held off for as long as a command runs
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         DATA_READY_HOLD <= 1'b0;
      end else begin
         DATA_READY_HOLD <= busy_next;
      end
   end
endmodule : id_scratch_flashcount_regs
`default_nettype wire

/* File: bench/idregs_checker.sv */
// checker: port-level properties of the id, scratch and flash-count bank
`timescale 1ns/10ps
`default_nettype none
module idregs_checker #(
   parameter logic [15:0] PRODUCT_CODE = 16'h1234, // arbitrary value
   parameter logic [15:0] LOT_SERIAL = 16'h0001
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire idregs_pkg::reg_req_type REQ,
   input wire logic FLASH_FAULT,
   input wire idregs_pkg::reg_rsp_type RSP,
   input wire logic DATA_READY_HOLD
);
   import idregs_pkg::*;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   logic [31:0] cnt_reg;
   logic fail_reg;
   logic [15:0] scr_reg;
   wire logic rk = REQ.rd && !RSP.busy;
   wire logic [6:0] ad = REQ.addr;
   // shadows; the result is taken when busy drops, so fault must hold through a commit
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         cnt_reg <= FLASH_COUNT_RESET;
         fail_reg <= 1'b0;
      end else if ($fell(RSP.busy)) begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
         fail_reg <= $past(FLASH_FAULT);
      end
   end
   // scratch a shadow, written only by writes the port takes
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         scr_reg <= SCRATCH_RESET;
      end else if (REQ.wr && !RSP.busy && ad == ADDR_USER_SCRATCH_A) begin
         scr_reg <= REQ.wdata;
      end
   end
   property p_id; rk && ad == ADDR_PRODUCT_IDENTIFIER |=>
      RSP.rvalid && RSP.rdata == PRODUCT_CODE; endproperty
   a_id: assert property (p_id) else $error("bad id word");
   property p_ser; rk && ad == ADDR_LOT_SERIAL_NUMBER |=>
      RSP.rvalid && RSP.rdata == LOT_SERIAL; endproperty
   a_ser: assert property (p_ser) else $error("bad serial");
   property p_scr; rk && ad == ADDR_USER_SCRATCH_A |=> RSP.rdata == scr_reg; endproperty
   a_scr: assert property (p_scr) else $error("bad scratch");
   property p_cnt; rk && ad == ADDR_FLASH_WRITES_LOW_WORD |=> RSP.rdata == cnt_reg[15:0];
   endproperty
   a_cnt: assert property (p_cnt) else $error("bad count");
   property p_hi; rk && ad == ADDR_FLASH_WRITES_HIGH_WORD |=> RSP.rdata == cnt_reg[31:16];
   endproperty
   a_hi: assert property (p_hi) else $error("bad count high");
   property p_hold; DATA_READY_HOLD == RSP.busy; endproperty
   a_hold: assert property (p_hold) else $error("hold differs from busy");
   property p_cmd; REQ.wr && !RSP.busy && ad == ADDR_GLOBAL_COMMAND &&
      REQ.wdata[CMD_FLASH_UPDATE_BIT] |=> RSP.busy && DATA_READY_HOLD; endproperty
   a_cmd: assert property (p_cmd) else $error("command not started");
   property p_dg; rk && ad == ADDR_DIAG_STATUS |=>
      RSP.rdata[DIAG_FLASH_FAIL_BIT] == fail_reg; endproperty
   a_dg: assert property (p_dg) else $error("bad result bit");
   c_commit: cover property ($fell(RSP.busy));
   c_fail: cover property ($fell(RSP.busy) && fail_reg);
   c_read: cover property (RSP.rvalid);
endmodule : idregs_checker
`default_nettype wire

/* File: bench/host_model.sv */
// host model: register-port master issuing single transfers and commits
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic MCLK,
   input wire idregs_pkg::reg_rsp_type RSP,
   output idregs_pkg::reg_req_type REQ
);
   import idregs_pkg::*;
   initial REQ = '0;
   // one-cycle pulse; released lines show the inverse so stale values never pass
   task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d,
         output logic [15:0] q);
      @(posedge MCLK);
      REQ <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge MCLK);
      REQ <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      @(posedge MCLK);
      q = RSP.rvalid ? RSP.rdata : 16'hxxxx;
   endtask : xfer
   // commit request, then a bounded wait for busy to drop
   task automatic commit(output logic ok);
      logic [15:0] q;
      xfer(1'b1, ADDR_GLOBAL_COMMAND, 16'h0008, q);
      ok = 1'b0;
      for (int i = 0; i < 200 && !ok; i++) begin
         @(posedge MCLK);
         ok = !RSP.busy;
      end
   endtask : commit
endmodule : host_model
`default_nettype wire

/* File: bench/id_scratch_flashcount_regs_tb.sv */
// testbench: id words, scratch words, commits, refusal while busy
`timescale 1ns/10ps
`default_nettype none
module id_scratch_flashcount_regs_tb;
   import idregs_pkg::*;
   logic MCLK = 1'b0;
   logic RST_N = 1'b0;
   logic FLASH_FAULT = 1'b0;
   reg_req_type REQ;
   reg_rsp_type RSP;
   logic DATA_READY_HOLD;
   int fails = 0;
   int samples_checked = 0;
   logic [15:0] q;
   logic ok;
   host_model host (.MCLK(MCLK), .RSP(RSP), .REQ(REQ));
   id_scratch_flashcount_regs #(.PRODUCT_CODE(16'h1234), .FLASH_CYCLES(4)) dut (.MCLK(MCLK),
      .RST_N(RST_N), .REQ(REQ), .FLASH_FAULT(FLASH_FAULT), .RSP(RSP),
      .DATA_READY_HOLD(DATA_READY_HOLD));
   initial forever #2 MCLK = ~MCLK;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rd(input logic [6:0] a, input logic [15:0] e, input string n);
      host.xfer(1'b0, a, 16'h0000, q);
      chk(n, e, q);
   endtask : rd
   task automatic final_report();
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // commit with fault held at the given level; a hang ends the run
   task automatic do_commit(input logic f);
      FLASH_FAULT <= f;
      host.commit(ok);
      if (!ok) begin
         fails++;
         final_report();
      end
   endtask : do_commit
   initial begin
      repeat (20) @(posedge MCLK);
      RST_N <= 1'b1;
      for (int i = 0; i < 3; i++) rd(ADDR_PRODUCT_IDENTIFIER, 16'h1234, "id");
      host.xfer(1'b1, ADDR_PRODUCT_IDENTIFIER, 16'h5555, q);
      host.xfer(1'b1, ADDR_LOT_SERIAL_NUMBER, 16'haaaa, q);
      rd(ADDR_PRODUCT_IDENTIFIER, 16'h1234, "id kept");
      rd(ADDR_LOT_SERIAL_NUMBER, 16'h0001, "serial");
      for (int i = 0; i < 3; i++) begin
         host.xfer(1'b1, 7'(ADDR_USER_SCRATCH_A + 2 * i), 16'(16'h0f0f + i * 16'h1111), q);
      end
      for (int i = 0; i < 3; i++) begin
         rd(7'(ADDR_USER_SCRATCH_A + 2 * i), 16'(16'h0f0f + i * 16'h1111), "scratch");
      end
      do_commit(1'b0);
      rd(ADDR_FLASH_WRITES_LOW_WORD, 16'h0001, "count low");
      rd(ADDR_DIAG_STATUS, 16'h0000, "pass bit");
      host.xfer(1'b1, ADDR_FLASH_WRITES_LOW_WORD, 16'h0000, q);
      FLASH_FAULT <= 1'b1;
      host.xfer(1'b1, ADDR_GLOBAL_COMMAND, 16'h0008, q);
      chk("hold", 16'h0001, {15'h0000, DATA_READY_HOLD});
      rd(ADDR_USER_SCRATCH_B, 16'hxxxx, "refused read");
      do_commit(1'b1);
      rd(ADDR_FLASH_WRITES_LOW_WORD, 16'h0002, "count low");
      rd(ADDR_FLASH_WRITES_HIGH_WORD, 16'h0000, "count high");
      host.xfer(1'b0, ADDR_DIAG_STATUS, 16'h0000, q);
      chk("fail bit", 16'h0004, q & 16'h0004);
      rd(ADDR_USER_SCRATCH_B, 16'h2020, "scratch kept");
      final_report();
   end
endmodule : id_scratch_flashcount_regs_tb
bind id_scratch_flashcount_regs idregs_checker #(.PRODUCT_CODE(PRODUCT_CODE),
   .LOT_SERIAL(LOT_SERIAL)) chk_i (.MCLK(MCLK), .RST_N(RST_N), .REQ(REQ),
   .FLASH_FAULT(FLASH_FAULT), .RSP(RSP), .DATA_READY_HOLD(DATA_READY_HOLD));
`default_nettype wire
